// file: hw/temp_limit_nvm_slave.v
// Temperature limit comparator, nonvolatile shadow store and two-wire bus slave
// Functional notes
// - Threshold mode bit 1 selects therm mode
// - Therm: result above high sets over flag
// - Therm: over flag clears only below low
// - Therm: under flag always reads zero
// - Therm: config reads leave flags unchanged
// - Therm: alert follows the over flag
// - Therm: reads keep alert
// - Polarity bit sets alert active level
// - After reset, 1.5 ms load from store
// - Writes ignored during load, reads served
// - Unlock-register busy flag reads cleared during load
// - Locked store: writes touch volatile registers only
// - Unlocked: each write to config, limit or general-purpose register programs store, 7 ms
// - Busy held during programming; controller polls
// - General-call reset reloads and relocks store
// - 8-bit pointer, resets to temperature
// - Slave only, SCL 1 kHz to 400 kHz
// - Words travel high byte first
// - START and STOP detected with SCL high
// - Address sampled on rising SCL, ninth-clock ack
// - Eight data clocks then acknowledge
// - Window mode: flags set, config read clears
// - General call with command 06h resets
`include "temp_limit_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module temp_limit_nvm_slave #(
    parameter [6:0] SLAVE_ADDR = 7'h48,
    parameter integer CNT_W = 18,
    parameter integer LOAD_CYCLES = `LOAD_TIME_US * `CORE_CLK_MHZ,
    parameter integer PROG_CYCLES = `PROG_TIME_US * `CORE_CLK_MHZ
) (
    input wire core_clk,
    input wire resetn,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    input wire conv_done,
    input wire [15:0] conv_result,
    output reg alert,
    output reg loading,
    output wire [1:0] conv_mode,
    output wire [2:0] conv_period,
    output wire [1:0] conv_avg
);

    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_ADDR = 6'b000010;
    localparam [5:0] ST_ACK = 6'b000100;
    localparam [5:0] ST_WRITE = 6'b001000;
    localparam [5:0] ST_READ = 6'b010000;
    localparam [5:0] ST_RACK = 6'b100000;

    // Input synchronisers
    reg scl_s1, scl_s2, scl_d;
    reg sda_s1, sda_s2, sda_d;
    reg sda_low;

    // Bus engine
    reg [5:0] state;
    reg [2:0] bit_cnt;
    reg byte_done;
    reg [7:0] rx;
    reg [7:0] tx;
    reg is_read;
    reg is_gc;
    reg [1:0] byte_idx;
    reg [7:0] wr_msb;
    reg rd_lsb;
    reg master_ack;
    reg [7:0] pointer;

    // Registers
    reg [15:0] temp_result;
    reg [15:0] cfg;
    reg [15:0] high_lim;
    reg [15:0] low_lim;
    reg [15:0] gp [1:3];
    reg unlock;
    reg high_flag;
    reg low_flag;
    reg data_ready;
    reg alert_act;
    reg [CNT_W-1:0] load_cnt;
    reg [CNT_W-1:0] prog_cnt;
    reg [15:0] nvm [0:7];

    reg sda_drv;
    reg [15:0] rd_word;

    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire therm = cfg[`CFG_THRESHOLD_MODE];
    wire nvm_busy = prog_cnt != {CNT_W{1'b0}};
    wire load_busy = load_cnt != {CNT_W{1'b0}};

    // Strobes from the bus engine
    wire wr_commit = (state == ST_WRITE) && scl_fall && byte_done && !is_gc
        && (byte_idx == 2'd2);
    wire [15:0] wr_data = {wr_msb, rx};
    wire soft_reset = (state == ST_WRITE) && scl_fall && byte_done && is_gc
        && (rx == `SOFT_RESET_CMD);
    wire rd_load = ((state == ST_ACK) && scl_fall && is_read)
        || ((state == ST_RACK) && scl_fall && master_ack);
    wire cfg_read = rd_load && !rd_lsb && (pointer == `PTR_CFG);
    wire temp_read = rd_load && !rd_lsb && (pointer == `PTR_TEMP);
    wire wr_ok = wr_commit && !load_busy;
    wire prog_ok = wr_ok && unlock && (pointer != `PTR_UNLOCK)
        && (pointer != `PTR_TEMP) && (pointer <= `PTR_GP3);
    wire over_high = $signed(conv_result) > $signed(high_lim);
    wire under_low = $signed(conv_result) < $signed(low_lim);

    // Slave only: SCL is never driven, SDA only pulled low
    assign sda_out = sda_low;
    assign conv_mode = cfg[`CFG_MODE_HI:`CFG_MODE_LO];
    assign conv_period = cfg[`CFG_PERIOD_HI:`CFG_PERIOD_LO];
    assign conv_avg = cfg[`CFG_AVG_HI:`CFG_AVG_LO];

    // Read data multiplexer
    always @* begin
        rd_word = 16'h0000;
        if (pointer == `PTR_TEMP) begin
            rd_word = temp_result;
        end else if (pointer == `PTR_CFG) begin
            rd_word = cfg & `CFG_WMASK;
            rd_word[`CFG_HIGH_FLAG] = high_flag;
            rd_word[`CFG_LOW_FLAG] = low_flag & ~therm;
            rd_word[`CFG_DATA_READY] = data_ready;
            rd_word[`CFG_NVM_BUSY] = nvm_busy;
        end else if (pointer == `PTR_HIGH) begin
            rd_word = high_lim;
        end else if (pointer == `PTR_LOW) begin
            rd_word = low_lim;
        end else if (pointer == `PTR_UNLOCK) begin
            rd_word[`UNL_UNLOCK] = unlock;
            rd_word[`UNL_BUSY] = nvm_busy & ~load_busy;
        end else if (pointer >= `PTR_GP1 && pointer <= `PTR_GP3) begin
            rd_word = gp[pointer[1:0]];
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    // Bus engine
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            bit_cnt <= 3'd0;
            byte_done <= 1'b0;
            rx <= 8'h00;
            tx <= 8'h00;
            is_read <= 1'b0;
            is_gc <= 1'b0;
            byte_idx <= 2'd0;
            wr_msb <= 8'h00;
            rd_lsb <= 1'b0;
            master_ack <= 1'b0;
            sda_drv <= 1'b0;
        end else if (bus_start) begin
            state <= ST_ADDR;
            bit_cnt <= 3'd0;
            byte_done <= 1'b0;
            sda_drv <= 1'b0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
            sda_drv <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        rx <= {rx[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 3'd1;
                        byte_done <= (bit_cnt == 3'd7);
                    end else if (scl_fall && byte_done) begin
                        byte_done <= 1'b0;
                        if (state == ST_ADDR) begin
                            byte_idx <= 2'd0;
                            rd_lsb <= 1'b0;
                            is_read <= rx[0];
                            is_gc <= (rx[7:1] == `GENERAL_CALL_ADDR);
                            if (rx[7:1] == SLAVE_ADDR
                                || (rx[7:1] == `GENERAL_CALL_ADDR && !rx[0])) begin
                                sda_drv <= 1'b1;
                                state <= ST_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            if (byte_idx == 2'd1) begin
                                wr_msb <= rx;
                            end
                            byte_idx <= (byte_idx == 2'd2) ? 2'd1 : byte_idx + 2'd1;
                            sda_drv <= 1'b1;
                            state <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 3'd0;
                        if (is_read) begin
                            tx <= {rd_word[14:8], 1'b0};
                            sda_drv <= ~rd_word[15];
                            rd_lsb <= 1'b1;
                            state <= ST_READ;
                        end else begin
                            sda_drv <= 1'b0;
                            state <= ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'd1;
                        byte_done <= (bit_cnt == 3'd7);
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            sda_drv <= 1'b0;
                            state <= ST_RACK;
                        end else begin
                            sda_drv <= ~tx[7];
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        master_ack <= ~sda_s2;
                    end else if (scl_fall) begin
                        bit_cnt <= 3'd0;
                        if (master_ack) begin
                            if (rd_lsb) begin
                                tx <= {rd_word[6:0], 1'b0};
                                sda_drv <= ~rd_word[7];
                            end else begin
                                tx <= {rd_word[14:8], 1'b0};
                                sda_drv <= ~rd_word[15];
                            end
                            rd_lsb <= ~rd_lsb;
                            state <= ST_READ;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_drv <= 1'b0;
                end
            endcase
        end
    end

    // Pin drive, low only
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sda_oe <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            sda_oe <= sda_drv;
            sda_low <= 1'b0;
        end
    end

    // Register file, store and comparator
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pointer <= `PTR_RESET;
            temp_result <= `TEMP_RESET;
            cfg <= `CFG_RESET;
            high_lim <= `HIGH_RESET;
            low_lim <= `LOW_RESET;
            gp[1] <= `GP_RESET;
            gp[2] <= `GP_RESET;
            gp[3] <= `GP_RESET;
            unlock <= 1'b0;
            high_flag <= 1'b0;
            low_flag <= 1'b0;
            data_ready <= 1'b0;
            load_cnt <= LOAD_CYCLES[CNT_W-1:0];
            prog_cnt <= {CNT_W{1'b0}};
            nvm[0] <= 16'h0000;
            nvm[1] <= `CFG_RESET;
            nvm[2] <= `HIGH_RESET;
            nvm[3] <= `LOW_RESET;
            nvm[4] <= 16'h0000;
            nvm[5] <= `GP_RESET;
            nvm[6] <= `GP_RESET;
            nvm[7] <= `GP_RESET;
        end else begin
            if ((state == ST_WRITE) && scl_fall && byte_done && !is_gc
                && byte_idx == 2'd0) begin
                pointer <= rx;
            end
            if (soft_reset) begin
                pointer <= `PTR_RESET;
                unlock <= 1'b0;
                load_cnt <= LOAD_CYCLES[CNT_W-1:0];
            end else if (load_busy) begin
                load_cnt <= load_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                if (load_cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    cfg <= nvm[1] & `CFG_WMASK;
                    high_lim <= nvm[2];
                    low_lim <= nvm[3];
                    gp[1] <= nvm[5];
                    gp[2] <= nvm[6];
                    gp[3] <= nvm[7];
                end
            end else if (wr_ok) begin
                if (pointer == `PTR_CFG) begin
                    cfg <= wr_data & `CFG_WMASK;
                end else if (pointer == `PTR_HIGH) begin
                    high_lim <= wr_data;
                end else if (pointer == `PTR_LOW) begin
                    low_lim <= wr_data;
                end else if (pointer == `PTR_UNLOCK) begin
                    unlock <= wr_data[`UNL_UNLOCK];
                end else if (pointer >= `PTR_GP1 && pointer <= `PTR_GP3) begin
                    gp[pointer[1:0]] <= wr_data;
                end
            end
            if (prog_ok) begin
                nvm[pointer[2:0]] <= (pointer == `PTR_CFG) ? (wr_data & `CFG_WMASK)
                    : wr_data;
                prog_cnt <= PROG_CYCLES[CNT_W-1:0];
            end else if (nvm_busy) begin
                prog_cnt <= prog_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
            end
            // Clears first, so a same-cycle conversion wins
            if (cfg_read || temp_read) begin
                data_ready <= 1'b0;
            end
            if (cfg_read && !therm) begin
                high_flag <= 1'b0;
                low_flag <= 1'b0;
            end
            if (conv_done) begin
                temp_result <= conv_result;
                data_ready <= 1'b1;
                if (therm) begin
                    low_flag <= 1'b0;
                    if (over_high) begin
                        high_flag <= 1'b1;
                    end else if (under_low) begin
                        high_flag <= 1'b0;
                    end
                end else begin
                    if (over_high) begin
                        high_flag <= 1'b1;
                    end
                    if (under_low) begin
                        low_flag <= 1'b1;
                    end
                end
            end
        end
    end

    // Alert pin
    always @* begin
        alert_act = therm ? high_flag : (high_flag | low_flag);
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            alert <= 1'b1;
            loading <= 1'b1;
        end else begin
            alert <= cfg[`CFG_POLARITY] ? alert_act : ~alert_act;
            loading <= load_busy;
        end
    end

endmodule // temp_limit_nvm_slave

`default_nettype wire

// file: hw/temp_limit_regs.vh
// Register offsets, field positions, reset values and timings of the sensor control block
`ifndef TEMP_LIMIT_REGS_VH
`define TEMP_LIMIT_REGS_VH

// Pointer values
`define PTR_TEMP 8'h00
`define PTR_CFG 8'h01
`define PTR_HIGH 8'h02
`define PTR_LOW 8'h03
`define PTR_UNLOCK 8'h04
`define PTR_GP1 8'h05
`define PTR_GP2 8'h06
`define PTR_GP3 8'h07
`define PTR_RESET 8'h00

// Configuration register fields
`define CFG_HIGH_FLAG 15
`define CFG_LOW_FLAG 14
`define CFG_DATA_READY 13
`define CFG_NVM_BUSY 12
`define CFG_MODE_HI 11
`define CFG_MODE_LO 10
`define CFG_PERIOD_HI 9
`define CFG_PERIOD_LO 7
`define CFG_AVG_HI 6
`define CFG_AVG_LO 5
`define CFG_THRESHOLD_MODE 4
`define CFG_POLARITY 3
`define CFG_WMASK 16'h0ffc

// Unlock register fields
`define UNL_UNLOCK 15
`define UNL_BUSY 14

// Reset values
`define TEMP_RESET 16'h8000
`define CFG_RESET 16'h0220
`define HIGH_RESET 16'h6000
`define LOW_RESET 16'h8000
`define GP_RESET 16'h0000

// Bus codes
`define GENERAL_CALL_ADDR 7'h00
`define SOFT_RESET_CMD 8'h06

// Timing
`define CORE_CLK_MHZ 25
`define LOAD_TIME_US 1500
`define PROG_TIME_US 7000

`endif

// file: tb/temp_limit_nvm_slave_props.sv
// Port-level assertions for the sensor control block
`timescale 1ns/1ns
`default_nettype none
module temp_limit_nvm_slave_props #(
    parameter integer CNT_W = 18,
    parameter integer LOAD_CYCLES = 37500
) (
    input wire core_clk,
    input wire resetn,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire conv_done,
    input wire [15:0] conv_result,
    input wire alert,
    input wire loading,
    input wire [1:0] conv_mode,
    input wire [2:0] conv_period,
    input wire [1:0] conv_avg
);
    localparam int LOAD_MIN = LOAD_CYCLES - 4;
    localparam int LOAD_MAX = LOAD_CYCLES + 4;
    logic [5:0] idle_cnt;
    logic scl_d;
    logic [CNT_W-1:0] load_cnt;
    // Idle counter saturates once SCL has been still for 40 cycles
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idle_cnt <= 6'h00;
            scl_d <= 1'b1;
            load_cnt <= '0;
        end else begin
            scl_d <= scl_in;
            if (scl_in != scl_d)
                idle_cnt <= 6'h00;
            else if (idle_cnt != 6'h28)
                idle_cnt <= idle_cnt + 6'h01;
            load_cnt <= loading ? load_cnt + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    property p_drive_low; sda_out == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda_out not low");
    property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda_oe moved with scl high");
    property p_oe_idle; idle_cnt == 6'h28 |-> !sda_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sda held on idle bus");
    property p_start_master; $fell(sda_in) && scl_in && $past(scl_in) |-> !$past(sda_oe); endproperty
    a_start_master: assert property (p_start_master) else $error("slave made a start");
    property p_load_len; $fell(loading) |-> load_cnt >= LOAD_MIN && load_cnt <= LOAD_MAX; endproperty
    a_load_len: assert property (p_load_len) else $error("load length wrong");
    property p_load_max; loading |-> load_cnt <= LOAD_MAX; endproperty
    a_load_max: assert property (p_load_max) else $error("load runs too long");
    property p_alert_cause;
        $changed(alert) |-> $past(conv_done, 2) || idle_cnt != 6'h28 || $past(loading) ||
            $past(loading, 2);
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert moved without cause");
    property p_fields_cause;
        $changed({conv_mode, conv_period, conv_avg}) |-> idle_cnt != 6'h28 || $past(loading) ||
            $past(loading, 2);
    endproperty
    a_fields_cause: assert property (p_fields_cause) else $error("config moved idle");
    c_load_done: cover property ($fell(loading));
    c_ack: cover property ($rose(sda_oe));
    c_alert_conv: cover property ($changed(alert) && $past(conv_done, 2));
endmodule // temp_limit_nvm_slave_props
bind temp_limit_nvm_slave temp_limit_nvm_slave_props #(.CNT_W(CNT_W), .LOAD_CYCLES(LOAD_CYCLES))
    i_temp_limit_nvm_slave_props (.core_clk(core_clk), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .conv_result(conv_result), .alert(alert), .loading(loading), .conv_mode(conv_mode),
    .conv_period(conv_period), .conv_avg(conv_avg));
`default_nettype wire

// file: tb/two_wire_master.sv
// Two-wire bus controller model driving SCL and pulling SDA
`timescale 1ns/1ns
`default_nettype none
module two_wire_master (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // 320 ns bit, SDA moves mid-low, sampled late in high
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        #80 sda_low = !b;
        #120 scl = 1'b1;
        #100 s = sda;
        #20;
    endtask
    // b=1 gives START, b=0 gives STOP
    task automatic cond(input logic b);
        @(posedge core_clk);
        #10 scl = 1'b0;
        #80 sda_low = !b;
        #120 scl = 1'b1;
        #100 sda_low = b;
        #100;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
            output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ai, s);
        ack = !s;
    endtask
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] ptr,
            input logic [15:0] d, input int n, output logic [15:0] q, output logic ok);
        logic k;
        logic [7:0] r;
        cond(1'b1);
        byte_io({a, rd}, 1'b1, r, ok);
        if (rd) begin
            byte_io(8'hff, 1'b0, q[15:8], k);
            byte_io(8'hff, 1'b1, q[7:0], k);
        end else begin
            byte_io(ptr, 1'b1, r, k);
            if (n > 0) begin
                byte_io(d[15:8], 1'b1, r, k);
                byte_io(d[7:0], 1'b1, r, k);
            end
        end
        cond(1'b0);
    endtask
endmodule // two_wire_master
`default_nettype wire

// file: tb/temp_limit_nvm_slave_bench.sv
// Self-checking bench for the sensor control block
`include "temp_limit_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module temp_limit_nvm_slave_bench;
    logic core_clk, resetn, conv_done, ok, flag;
    logic [15:0] conv_result, q, hi, lo, gp;
    logic [15:0] rs [5];
    logic [31:0] seed = 32'h8402;
    int n_errors = 0;
    int comparisons = 0;
    int i, j, k;
    wire sda_oe, sda_out, alert, loading, scl, sda_low;
    wire [1:0] conv_mode, conv_avg;
    wire [2:0] conv_period;
    wire sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    temp_limit_nvm_slave #(.LOAD_CYCLES(2000), .PROG_CYCLES(1000)) i_temp_limit_nvm_slave (
        .core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .conv_done(conv_done), .conv_result(conv_result), .alert(alert),
        .loading(loading), .conv_mode(conv_mode), .conv_period(conv_period), .conv_avg(conv_avg));
    two_wire_master i_two_wire_master (.core_clk(core_clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic therm(input logic f, input logic [15:0] t, h, l);
        if ($signed(t) > $signed(h)) return 1'b1;
        if ($signed(t) < $signed(l)) return 1'b0;
        return f;
    endfunction
    task automatic print_verdict;
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk16(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
        i_two_wire_master.xfer(7'h48, 1'b0, p, d, n, q, ok);
        chk1("ack", 1'b1, ok);
    endtask
    task automatic rx;
        i_two_wire_master.xfer(7'h48, 1'b1, 8'h00, 16'h0000, 0, q, ok);
    endtask
    task automatic rd(input logic [7:0] p);
        wr(p, 16'h0000, 0);
        rx;
    endtask
    task automatic conv(input logic [15:0] t);
        @(posedge core_clk);
        conv_done <= 1'b1;
        conv_result <= t;
        @(posedge core_clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wait_load;
        for (k = 0; k < 4000 && loading !== 1'b0; k++)
            @(posedge core_clk);
        chk1("load_end", 1'b0, loading);
        if (loading !== 1'b0)
            print_verdict;
    endtask
    initial begin
        resetn = 1'b0;
        conv_done = 1'b0;
        conv_result = 16'h0000;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        rx;
        chk16("temp", `TEMP_RESET, q);
        chk1("loading", 1'b1, loading);
        wr(`PTR_HIGH, 16'h1234, 2);
        rd(`PTR_UNLOCK);
        chk16("busy_load", 16'h0000, q);
        wait_load;
        rd(`PTR_HIGH);
        chk16("high", `HIGH_RESET, q);
        rd(8'h08);
        chk16("unmapped", 16'h0000, q);
        i_two_wire_master.xfer(7'h49, 1'b1, 8'h00, 16'h0000, 0, q, ok);
        chk1("nack", 1'b0, ok);
        wr(`PTR_CFG, 16'h0230, 2);
        flag = 1'b0;
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            hi = {2'b00, seed[13:0]} + 16'h0100;
            lo = hi - {8'h00, seed[21:14]} - 16'h0002;
            rs = '{hi, hi + 16'h0001, lo, seed[31:16], lo - 16'h0001};
            wr(`PTR_HIGH, hi, 2);
            wr(`PTR_LOW, lo, 2);
            for (j = 0; j < 5; j++) begin
                conv(rs[j]);
                flag = therm(flag, rs[j], hi, lo);
                chk1("alert", !flag, alert);
                rd(`PTR_CFG);
                chk16("flags", {14'h0000, flag, 1'b0}, {14'h0000, q[15:14]});
                chk1("alert_kept", !flag, alert);
            end
        end
        wr(`PTR_CFG, 16'h0238, 2);
        conv(hi + 16'h0001);
        chk1("alert_pol", 1'b1, alert);
        wr(`PTR_CFG, 16'h0228, 2);
        conv(lo - 16'h0001);
        rd(`PTR_CFG);
        chk16("win_flags", 16'h0003, {14'h0000, q[15:14]});
        chk1("win_alert", 1'b0, alert);
        wr(`PTR_CFG, 16'h0620, 2);
        wr(`PTR_GP2, 16'h5a5a, 2);
        wr(`PTR_UNLOCK, 16'h8000, 2);
        seed = lfsr(seed);
        gp = seed[15:0];
        wr(`PTR_GP1, gp, 2);
        rd(`PTR_UNLOCK);
        chk16("busy", 16'hc000, q);
        for (j = 0; j < 20 && q[14] !== 1'b0; j++)
            rx;
        chk16("busy_done", 16'h8000, q);
        if (q !== 16'h8000)
            print_verdict;
        i_two_wire_master.xfer(`GENERAL_CALL_ADDR, 1'b0, `SOFT_RESET_CMD, 16'h0000, 0, q, ok);
        chk1("gc_ack", 1'b1, ok);
        repeat (4) @(posedge core_clk);
        chk1("reload", 1'b1, loading);
        wait_load;
        rd(`PTR_GP1);
        chk16("gp1", gp, q);
        rd(`PTR_GP2);
        chk16("gp2", `GP_RESET, q);
        rd(`PTR_UNLOCK);
        chk16("relock", 16'h0000, q);
        rd(`PTR_CFG);
        chk16("cfg", `CFG_RESET & `CFG_WMASK, q & `CFG_WMASK);
        chk16("fields", 16'h0011, {9'h000, conv_mode, conv_period, conv_avg});
        print_verdict;
    end
endmodule // temp_limit_nvm_slave_bench
`default_nettype wire
